/* File: hw/asps_pkg.sv */
package asps_pkg;
   // clock and the one-second time base
   localparam int          CLK_HZ      = 50_000_000;
   localparam int          TICK_S      = 1;
   localparam int          TICK_CYC    = TICK_S * CLK_HZ;
   localparam int          TICK_W      = 26;
   // source table geometry
   localparam int          PORT_W      = 8;
   localparam int          KEY_W       = 56;
   localparam int          IDX_W       = 4;
   localparam int          DEPTH       = 16;
   localparam int          CNT_W       = 16;
   localparam logic [4:0]  HYB_MAX     = 5'h08;
   // ip protocol numbers
   localparam logic [7:0]  PROTO_ICMP  = 8'h01;
   localparam logic [7:0]  PROTO_IGMP  = 8'h02;
   localparam logic [7:0]  PROTO_TCP   = 8'h06;
   localparam logic [7:0]  PROTO_UDP   = 8'h11;
   // tcp flag bit positions
   localparam int          FL_FIN      = 0;
   localparam int          FL_SYN      = 1;
   localparam int          FL_RST      = 2;
   localparam int          FL_ACK      = 4;
   // smallest whole l4 header in a first fragment, bytes
   localparam logic [15:0] TCP_HDR_B   = 16'h0014;
   localparam logic [15:0] L4_HDR_B    = 16'h0008;
   // default polling threshold is thr * POLL_NUM >> POLL_SHR
   localparam logic [1:0]  POLL_NUM    = 2'h3;
   localparam int          POLL_SHR    = 2;
   // attack type held by an ip-table entry
   localparam logic        TYP_IP      = 1'b0;
   localparam logic        TYP_IGMP    = 1'b1;

   typedef enum logic [1:0] {
      ASPS_IDLE  = 2'b00,
      ASPS_LOOK  = 2'b01,
      ASPS_SWEEP = 2'b10
   } asps_st_e;

   typedef struct packed {
      logic             vld;
      logic             blk;
      logic             hyb;
      logic             typ;
      logic [KEY_W-1:0] key;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] tmr;
   } asps_ent_s;

   localparam int          ENT_W       = $bits(asps_ent_s);
endpackage

/* File: hw/asps_mem.sv */
`timescale 1ns/1ps
module asps_mem
   import asps_pkg::*;
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // read port, data registered
   input  wire logic [IDX_W-1:0] rd_addr_i,
   output logic      [ENT_W-1:0] rd_data_o,
   // write port
   input  wire logic             wr_en_i,
   input  wire logic [IDX_W-1:0] wr_addr_i,
   input  wire logic [ENT_W-1:0] wr_data_i
);
   logic [ENT_W-1:0] mem [DEPTH];
   logic [ENT_W-1:0] rd_ff;
   logic [ENT_W-1:0] nxt_rd;

   always_comb begin
      nxt_rd = mem[rd_addr_i];
   end

   // contents are not reset; the owner wipes the valid bits after reset
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      if (!reset_n_i) begin
         rd_ff <= '0;
      end else begin
         rd_ff <= nxt_rd;
      end
   end

   assign rd_data_o = rd_ff;
endmodule

/* File: hw/asps_screener.sv */
`timescale 1ns/1ps
module asps_screener
   import asps_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   // parsed packet header
   input  wire logic              pkt_valid_i,
   output logic                   pkt_ready_o,
   input  wire logic [PORT_W-1:0] pkt_port_i,
   input  wire logic [47:0]       pkt_smac_i,
   input  wire logic [47:0]       pkt_dmac_i,
   input  wire logic              pkt_is_arp_i,
   input  wire logic              pkt_is_ip_i,
   input  wire logic [31:0]       pkt_sip_i,
   input  wire logic [31:0]       pkt_dip_i,
   input  wire logic [7:0]        pkt_proto_i,
   input  wire logic [15:0]       pkt_sport_i,
   input  wire logic [15:0]       pkt_dport_i,
   input  wire logic [5:0]        pkt_tcp_flags_i,
   input  wire logic [7:0]        pkt_tcp_hlen_i,
   input  wire logic [15:0]       pkt_len_i,
   input  wire logic              pkt_frag_mf_i,
   input  wire logic [12:0]       pkt_frag_off_i,
   input  wire logic [15:0]       pkt_ip_pay_i,
   // verdict
   output logic                   verdict_valid_o,
   output logic                   verdict_drop_o,
   output logic                   verdict_mal_o,
   output logic                   verdict_blk_o,
   // malformed-packet checks
   input  wire logic              chk_all_i,
   input  wire logic              chk_ip_land_i,
   input  wire logic              chk_mac_land_i,
   input  wire logic              equal_l4_port_check_i,
   input  wire logic              chk_icmp_size_i,
   input  wire logic [15:0]       icmp_max_len_i,
   input  wire logic              chk_tcp_flags_i,
   input  wire logic              chk_tcp_short_i,
   input  wire logic [7:0]        tcp_min_hdr_i,
   input  wire logic              first_fragment_check_i,
   // source filter
   input  wire logic              flt_en_i,
   input  wire logic              flt_hybrid_i,
   input  wire logic              flt_arp_i,
   input  wire logic              flt_igmp_i,
   input  wire logic              flt_ip_i,
   input  wire logic [15:0]       flt_period_i,
   input  wire logic [CNT_W-1:0]  flt_thr_i,
   input  wire logic [15:0]       flt_block_time_i,
   input  wire logic              poll_autofit_i,
   input  wire logic [15:0]       poll_period_i,
   input  wire logic [CNT_W-1:0]  poll_thr_i,
   // status
   output logic [4:0]             hyb_used_o,
   output logic                   flt_busy_o
);
   asps_st_e         st_ff, nxt_st;
   logic [TICK_W-1:0] tick_ff, nxt_tick;
   logic [15:0]      per_ff, nxt_per;
   logic [IDX_W-1:0] sw_ff, nxt_sw;
   logic             sec_ff, nxt_sec, clr_ff, nxt_clr, wipe_ff, nxt_wipe, en_d_ff;
   logic [4:0]       hyb_ff, nxt_hyb;
   logic [KEY_W-1:0] kmac_ff, nxt_kmac, kip_ff, nxt_kip;
   logic             arp_ff, nxt_arp, ip_ff, nxt_ip, igmp_ff, nxt_igmp;
   logic             mal_ff, nxt_mal;
   logic             vv_ff, nxt_vv, vd_ff, nxt_vd, vm_ff, nxt_vm, vb_ff, nxt_vb;
   logic [IDX_W-1:0] ra_mac, ra_ip, wa_mac, wa_ip;
   logic             we_mac, we_ip;
   asps_ent_s        rd_mac, rd_ip, wd_mac, wd_ip;
   logic [CNT_W-1:0] eff_pthr;
   logic [15:0]      eff_pper;
   logic             sec_now, per_end, ck_tcp, ck_udp, ck_icmp, ck_igmp;
   logic             hit_mac, hit_ip, hyb_ok_mac, hyb_ok_ip, new_mac, new_ip;
   logic             rel_mac, rel_ip, cnt_ip;

   function automatic logic [IDX_W-1:0] hash(input logic [KEY_W-1:0] k);
      logic [IDX_W-1:0] h;
      h = '0;
      for (int i = 0; i < KEY_W; i += IDX_W) begin
         h = h ^ k[i +: IDX_W];
      end
      return h;
   endfunction

   function automatic logic bad_flags(input logic [5:0] f);
      bad_flags = (f == 6'h00) || (f[FL_SYN] && f[FL_FIN]) ||
                  (f[FL_SYN] && f[FL_RST]) || (f[FL_FIN] && !f[FL_ACK]);
   endfunction

   // count one packet for a source and detect it
   function automatic asps_ent_s count_ent(input asps_ent_s e0, input logic [KEY_W-1:0] k,
                                           input logic t, input logic hok,
                                           input logic [CNT_W-1:0] thr,
                                           input logic [15:0] btime,
                                           input logic [15:0] pper);
      asps_ent_s e;
      e = e0;
      if (!(e.vld && e.key == k) && e.vld && e.blk) begin
         // index held by another blocked source: that block is not displaced
         e = e0;
      end else begin
         if (!(e.vld && e.key == k)) begin
            e = '0;
            e.vld = 1'b1;
            e.key = k;
         end
         if (!e.blk) begin
            e.typ = t;
         end
         if (e.cnt != '1) begin
            e.cnt = e.cnt + 1'b1;
         end
         if (!e.blk && e.cnt > thr) begin
            e.blk = 1'b1;
            e.hyb = hok;
            e.tmr = hok ? pper : btime;
            e.cnt = '0;
         end
      end
      return e;
   endfunction

   // per-second ageing of one entry
   function automatic asps_ent_s age_ent(input asps_ent_s e0, input logic sec,
                                         input logic clr, input logic wipe,
                                         input logic [CNT_W-1:0] pthr,
                                         input logic [15:0] pper);
      asps_ent_s e;
      e = e0;
      if (wipe) begin
         e.vld = 1'b0;
         e.blk = 1'b0;
      end else if (e.vld && e.blk) begin
         if (sec) begin
            if (e.tmr <= 16'h0001) begin
               if (e.hyb && e.cnt > pthr) begin
                  e.tmr = pper;
               end else begin
                  e.blk = 1'b0;
                  e.hyb = 1'b0;
               end
               e.cnt = '0;
            end else begin
               e.tmr = e.tmr - 16'h0001;
            end
         end
      end else if (clr) begin
         e.cnt = '0;
      end
      return e;
   endfunction

   function automatic logic ck(input logic en);
      ck = chk_all_i || en;
   endfunction

   asps_mem u_mac_tab (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .rd_addr_i (ra_mac),
      .rd_data_o (rd_mac),
      .wr_en_i   (we_mac),
      .wr_addr_i (wa_mac),
      .wr_data_i (wd_mac)
   );

   asps_mem u_ip_tab (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .rd_addr_i (ra_ip),
      .rd_data_o (rd_ip),
      .wr_en_i   (we_ip),
      .wr_addr_i (wa_ip),
      .wr_data_i (wd_ip)
   );

   always_comb begin
      eff_pthr = poll_autofit_i ?
                 CNT_W'((18'(flt_thr_i) * 18'(POLL_NUM)) >> POLL_SHR) : poll_thr_i;
      eff_pper = poll_autofit_i ? flt_period_i : poll_period_i;
      sec_now  = (tick_ff == TICK_W'(TICK_CYCLES - 1));
      per_end  = sec_now && (per_ff + 16'h0001 >= flt_period_i);
      ck_tcp   = pkt_is_ip_i && pkt_proto_i == PROTO_TCP;
      ck_udp   = pkt_is_ip_i && pkt_proto_i == PROTO_UDP;
      ck_icmp  = pkt_is_ip_i && pkt_proto_i == PROTO_ICMP;
      ck_igmp  = pkt_is_ip_i && pkt_proto_i == PROTO_IGMP;
      // entries used for a packet decision, before this packet's update
      hit_mac  = rd_mac.vld && rd_mac.blk && rd_mac.key == kmac_ff;
      hit_ip   = rd_ip.vld && rd_ip.blk && rd_ip.key == kip_ff;
      cnt_ip   = flt_igmp_i ? igmp_ff : (flt_ip_i && ip_ff);
      hyb_ok_mac = flt_hybrid_i && hyb_ff < HYB_MAX;
      new_mac  = 1'b0;
      new_ip   = 1'b0;
      rel_mac  = 1'b0;
      rel_ip   = 1'b0;
      ra_mac   = hash({pkt_port_i, pkt_smac_i});
      ra_ip    = hash({pkt_port_i, 16'h0000, pkt_sip_i});
      we_mac   = 1'b0;
      we_ip    = 1'b0;
      wa_mac   = hash(kmac_ff);
      wa_ip    = hash(kip_ff);
      wd_mac   = rd_mac;
      wd_ip    = rd_ip;
      hyb_ok_ip = 1'b0;
      nxt_st   = st_ff;
      nxt_tick = sec_now ? '0 : tick_ff + 1'b1;
      nxt_per  = flt_en_i ? (per_end ? 16'h0000 : per_ff + 16'(sec_now)) : 16'h0000;
      nxt_sw   = sw_ff;
      nxt_sec  = sec_ff;
      nxt_clr  = clr_ff;
      nxt_wipe = wipe_ff;
      nxt_hyb  = hyb_ff;
      nxt_kmac = kmac_ff;
      nxt_kip  = kip_ff;
      nxt_arp  = arp_ff;
      nxt_ip   = ip_ff;
      nxt_igmp = igmp_ff;
      nxt_mal  = mal_ff;
      nxt_vv   = 1'b0;
      nxt_vd   = vd_ff;
      nxt_vm   = vm_ff;
      nxt_vb   = vb_ff;
      case (st_ff)
         ASPS_IDLE: begin
            if (sec_ff || clr_ff || wipe_ff) begin
               ra_mac = sw_ff;
               ra_ip  = sw_ff;
               nxt_st = ASPS_SWEEP;
            end else if (pkt_valid_i) begin
               nxt_kmac = {pkt_port_i, pkt_smac_i};
               nxt_kip  = {pkt_port_i, 16'h0000, pkt_sip_i};
               nxt_arp  = pkt_is_arp_i;
               nxt_ip   = pkt_is_ip_i;
               nxt_igmp = ck_igmp;
               nxt_mal  =
                  (ck(chk_ip_land_i) && pkt_is_ip_i && pkt_sip_i == pkt_dip_i) ||
                  (ck(chk_mac_land_i) && pkt_smac_i == pkt_dmac_i) ||
                  (ck(equal_l4_port_check_i) && (ck_tcp || ck_udp) &&
                   pkt_sport_i == pkt_dport_i) ||
                  (ck(chk_icmp_size_i) && ck_icmp && pkt_len_i > icmp_max_len_i) ||
                  (ck(chk_tcp_flags_i) && ck_tcp && bad_flags(pkt_tcp_flags_i)) ||
                  (ck(chk_tcp_short_i) && ck_tcp && pkt_tcp_hlen_i <= tcp_min_hdr_i) ||
                  (ck(first_fragment_check_i) && pkt_is_ip_i && pkt_frag_mf_i &&
                   pkt_frag_off_i == 13'h0000 &&
                   pkt_ip_pay_i < (ck_tcp ? TCP_HDR_B : L4_HDR_B));
               nxt_st   = ASPS_LOOK;
            end
         end
         ASPS_LOOK: begin
            nxt_vv = 1'b1;
            nxt_vm = mal_ff;
            // a hybrid block only stops its own attack type
            nxt_vb = flt_en_i && (
                     (hit_mac && (!rd_mac.hyb || arp_ff)) ||
                     (hit_ip && ip_ff && (!rd_ip.hyb ||
                      (rd_ip.typ == TYP_IP) || igmp_ff)));
            nxt_vd = mal_ff || nxt_vb;
            if (flt_en_i && flt_arp_i && arp_ff) begin
               we_mac  = 1'b1;
               wd_mac  = count_ent(rd_mac, kmac_ff, TYP_IP, hyb_ok_mac, flt_thr_i,
                                   flt_block_time_i, eff_pper);
               new_mac = wd_mac.blk && wd_mac.hyb && !(hit_mac && rd_mac.hyb);
            end
            hyb_ok_ip = flt_hybrid_i && (hyb_ff + 5'(new_mac)) < HYB_MAX;
            if (flt_en_i && cnt_ip) begin
               we_ip  = 1'b1;
               wd_ip  = count_ent(rd_ip, kip_ff, flt_igmp_i ? TYP_IGMP : TYP_IP, hyb_ok_ip,
                                  flt_thr_i, flt_block_time_i, eff_pper);
               new_ip = wd_ip.blk && wd_ip.hyb && !(hit_ip && rd_ip.hyb);
            end
            nxt_hyb = hyb_ff + 5'(new_mac) + 5'(new_ip);
            nxt_st  = ASPS_IDLE;
         end
         ASPS_SWEEP: begin
            we_mac  = 1'b1;
            we_ip   = 1'b1;
            wa_mac  = sw_ff;
            wa_ip   = sw_ff;
            wd_mac  = age_ent(rd_mac, sec_ff, clr_ff, wipe_ff, eff_pthr, eff_pper);
            wd_ip   = age_ent(rd_ip, sec_ff, clr_ff, wipe_ff, eff_pthr, eff_pper);
            rel_mac = rd_mac.vld && rd_mac.blk && rd_mac.hyb && !wd_mac.blk;
            rel_ip  = rd_ip.vld && rd_ip.blk && rd_ip.hyb && !wd_ip.blk;
            nxt_hyb = wipe_ff ? 5'h00 : hyb_ff - 5'(rel_mac) - 5'(rel_ip);
            nxt_sw  = sw_ff + 1'b1;
            if (sw_ff == IDX_W'(DEPTH - 1)) begin
               nxt_sec  = 1'b0;
               nxt_clr  = 1'b0;
               nxt_wipe = 1'b0;
            end
            nxt_st  = ASPS_IDLE;
         end
         default: begin
            nxt_st = ASPS_IDLE;
         end
      endcase
      // a new trigger wins over the end-of-sweep clear
      if (sec_now && flt_en_i) begin
         nxt_sec = 1'b1;
      end
      if (per_end && flt_en_i) begin
         nxt_clr = 1'b1;
      end
      if (en_d_ff && !flt_en_i) begin
         nxt_wipe = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_ff   <= ASPS_IDLE;
         tick_ff <= '0;
         per_ff  <= 16'h0000;
         sw_ff   <= '0;
         sec_ff  <= 1'b0;
         clr_ff  <= 1'b0;
         // table contents are unknown after power-up
         wipe_ff <= 1'b1;
         en_d_ff <= 1'b0;
         hyb_ff  <= 5'h00;
         kmac_ff <= '0;
         kip_ff  <= '0;
         arp_ff  <= 1'b0;
         ip_ff   <= 1'b0;
         igmp_ff <= 1'b0;
         mal_ff  <= 1'b0;
         vv_ff   <= 1'b0;
         vd_ff   <= 1'b0;
         vm_ff   <= 1'b0;
         vb_ff   <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         tick_ff <= nxt_tick;
         per_ff  <= nxt_per;
         sw_ff   <= nxt_sw;
         sec_ff  <= nxt_sec;
         clr_ff  <= nxt_clr;
         wipe_ff <= nxt_wipe;
         en_d_ff <= flt_en_i;
         hyb_ff  <= nxt_hyb;
         kmac_ff <= nxt_kmac;
         kip_ff  <= nxt_kip;
         arp_ff  <= nxt_arp;
         ip_ff   <= nxt_ip;
         igmp_ff <= nxt_igmp;
         mal_ff  <= nxt_mal;
         vv_ff   <= nxt_vv;
         vd_ff   <= nxt_vd;
         vm_ff   <= nxt_vm;
         vb_ff   <= nxt_vb;
      end
   end

   assign pkt_ready_o     = (st_ff == ASPS_IDLE) && !(sec_ff || clr_ff || wipe_ff);
   assign verdict_valid_o = vv_ff;
   assign verdict_drop_o  = vd_ff;
   assign verdict_mal_o   = vm_ff;
   assign verdict_blk_o   = vb_ff;
   assign hyb_used_o      = hyb_ff;
   assign flt_busy_o      = sec_ff || clr_ff || wipe_ff;
endmodule

/* File: verification/asps_ingress_model.sv */
`timescale 1ns/1ps
module asps_ingress_model
   import asps_pkg::*;
(
   // clock and handshake
   input  wire logic         clk_i,
   input  wire logic         pkt_ready_i,
   // header toward the screener
   output logic              valid_o,
   output logic [PORT_W-1:0] port_o,
   output logic [47:0]       smac_o,
   output logic [47:0]       dmac_o,
   output logic              arp_o,
   output logic              ip_o,
   output logic [31:0]       sip_o,
   output logic [31:0]       dip_o,
   output logic [7:0]        proto_o,
   output logic [15:0]       sport_o,
   output logic [15:0]       dport_o,
   output logic [5:0]        flags_o,
   output logic [7:0]        hlen_o,
   output logic [15:0]       len_o,
   output logic              mf_o,
   output logic [12:0]       off_o,
   output logic [15:0]       pay_o
);
   initial begin
      valid_o = 1'b0;
      {port_o, smac_o, dmac_o, arp_o, ip_o, sip_o, dip_o, proto_o} = '0;
      {sport_o, dport_o, flags_o, hlen_o, len_o, mf_o, off_o, pay_o} = '0;
   end

   // kind 0 is a clean udp header, 1..7 break one check each, 8 is arp
   task automatic send(input int k, input logic [47:0] mac, input logic [7:0] p,
                       output bit ok);
      int n;
      @(negedge clk_i);
      {port_o, smac_o, dmac_o, arp_o, ip_o} = {p, mac, 48'h0200_0000_00FE, 2'h1};
      {sip_o, dip_o, proto_o} = {32'h0A00_0001, 32'h0A00_0002, PROTO_UDP};
      {sport_o, dport_o, flags_o, hlen_o} = {16'h1000, 16'h2000, 6'h10, 8'h14};
      {len_o, mf_o, off_o, pay_o} = {16'h0040, 14'h0000, 16'h0064};
      case (k)
         1: dip_o = sip_o;
         2: dmac_o = smac_o;
         3: dport_o = sport_o;
         4: {proto_o, len_o} = {PROTO_ICMP, 16'h0100};
         5: {proto_o, flags_o} = {PROTO_TCP, 6'h03};
         6: {proto_o, hlen_o} = {PROTO_TCP, 8'h13};
         7: {mf_o, pay_o} = {1'b1, 16'h0007};
         8: {arp_o, ip_o} = 2'h2;
         default: ;
      endcase
      valid_o = 1'b1;
      ok = 1'b0;
      // ready comes from registers, so its value between edges is what the next edge takes
      for (n = 0; n < 200 && !ok; n++) begin
         ok = pkt_ready_i;
         @(posedge clk_i);
         if (!ok) @(negedge clk_i);
      end
      @(negedge clk_i);
      valid_o = 1'b0;
      // released fields must not look like the last header
      {sip_o, dip_o, smac_o, dmac_o, sport_o} = ~{sip_o, dip_o, smac_o, dmac_o, sport_o};
   endtask
endmodule

/* File: verification/asps_screener_monitor.sv */
`timescale 1ns/1ps
module asps_screener_monitor
   import asps_pkg::*;
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // header
   input wire logic        pkt_valid_i,
   input wire logic        pkt_ready_o,
   input wire logic [47:0] pkt_smac_i,
   input wire logic [47:0] pkt_dmac_i,
   input wire logic        pkt_is_ip_i,
   input wire logic [31:0] pkt_sip_i,
   input wire logic [31:0] pkt_dip_i,
   input wire logic [7:0]  pkt_proto_i,
   input wire logic [15:0] pkt_sport_i,
   input wire logic [15:0] pkt_dport_i,
   input wire logic [15:0] pkt_len_i,
   // verdict
   input wire logic        verdict_valid_o,
   input wire logic        verdict_drop_o,
   input wire logic        verdict_mal_o,
   input wire logic        verdict_blk_o,
   // configuration and status
   input wire logic        chk_all_i,
   input wire logic        chk_ip_land_i,
   input wire logic        chk_mac_land_i,
   input wire logic        equal_l4_port_check_i,
   input wire logic        chk_icmp_size_i,
   input wire logic [15:0] icmp_max_len_i,
   input wire logic        flt_en_i,
   input wire logic [4:0]  hyb_used_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   wire take = pkt_valid_i && pkt_ready_o;

   AST_LATENCY: assert property (take |-> ##2 verdict_valid_o)
      else $error("verdict not two cycles after take");
   AST_NO_B2B: assert property (take |=> !pkt_ready_o)
      else $error("header taken back to back");
   AST_PULSE: assert property (verdict_valid_o |=> !verdict_valid_o)
      else $error("verdict pulse longer than one cycle");
   AST_HOLD: assert property (!verdict_valid_o |-> $stable(verdict_drop_o))
      else $error("drop changed between verdicts");
   AST_DROP_OR: assert property (verdict_valid_o |-> verdict_drop_o == (verdict_mal_o || verdict_blk_o))
      else $error("drop differs from mal or blk");
   AST_IP_LAND: assert property (
      take && pkt_is_ip_i && (chk_all_i || chk_ip_land_i) && pkt_sip_i == pkt_dip_i
      |-> ##2 verdict_mal_o && verdict_drop_o) else $error("ip land not dropped");
   AST_MAC_LAND: assert property (
      take && (chk_all_i || chk_mac_land_i) && pkt_smac_i == pkt_dmac_i |-> ##2 verdict_mal_o)
      else $error("mac land not dropped");
   AST_L4_PORT: assert property (
      take && pkt_is_ip_i && (chk_all_i || equal_l4_port_check_i) && pkt_sport_i == pkt_dport_i
      && (pkt_proto_i == PROTO_TCP || pkt_proto_i == PROTO_UDP) |-> ##2 verdict_mal_o)
      else $error("equal l4 ports not dropped");
   AST_ICMP: assert property (
      take && pkt_is_ip_i && (chk_all_i || chk_icmp_size_i) && pkt_proto_i == PROTO_ICMP
      && pkt_len_i > icmp_max_len_i |-> ##2 verdict_mal_o) else $error("long icmp not dropped");
   AST_FLT_OFF: assert property (
      take && !flt_en_i ##1 !flt_en_i ##1 !flt_en_i |-> !verdict_blk_o)
      else $error("block with filter disabled");
   AST_HYB_CAP: assert property (hyb_used_o <= HYB_MAX)
      else $error("hybrid entries above capacity");
endmodule

bind asps_screener asps_screener_monitor i_asps_screener_monitor (.*);

/* File: verification/tb_asps_screener.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module tb_asps_screener;
   logic        clk_i = 1'b0, reset_n_i = 1'b0, chk_all_i = 1'b0, flt_en_i = 1'b0;
   logic        flt_hybrid_i = 1'b0, flt_arp_i = 1'b1, flt_igmp_i = 1'b0, flt_ip_i = 1'b0;
   logic        poll_autofit_i = 1'b1;
   logic [6:0]  ce = 7'h00;
   logic [7:0]  tcp_min_hdr_i = 8'h13;
   logic [15:0] icmp_max_len_i = 16'h00FF, flt_period_i = 16'h0005, flt_thr_i = 16'h0003;
   logic [15:0] flt_block_time_i = 16'h0002, poll_period_i = 16'h0005, poll_thr_i = 16'h0002;
   int          fails = 0, n_compared = 0;
   wire         pkt_valid_i, pkt_ready_o, pkt_is_arp_i, pkt_is_ip_i, pkt_frag_mf_i, flt_busy_o;
   wire         verdict_valid_o, verdict_drop_o, verdict_mal_o, verdict_blk_o;
   wire [7:0]   pkt_port_i, pkt_proto_i, pkt_tcp_hlen_i;
   wire [47:0]  pkt_smac_i, pkt_dmac_i;
   wire [31:0]  pkt_sip_i, pkt_dip_i;
   wire [15:0]  pkt_sport_i, pkt_dport_i, pkt_len_i, pkt_ip_pay_i;
   wire [5:0]   pkt_tcp_flags_i;
   wire [12:0]  pkt_frag_off_i;
   wire [4:0]   hyb_used_o;

   always #10 clk_i = ~clk_i;

   asps_ingress_model i_asps_ingress_model (
      .clk_i(clk_i), .pkt_ready_i(pkt_ready_o), .valid_o(pkt_valid_i), .port_o(pkt_port_i),
      .smac_o(pkt_smac_i), .dmac_o(pkt_dmac_i), .arp_o(pkt_is_arp_i), .ip_o(pkt_is_ip_i),
      .sip_o(pkt_sip_i), .dip_o(pkt_dip_i), .proto_o(pkt_proto_i), .sport_o(pkt_sport_i),
      .dport_o(pkt_dport_i), .flags_o(pkt_tcp_flags_i), .hlen_o(pkt_tcp_hlen_i),
      .len_o(pkt_len_i), .mf_o(pkt_frag_mf_i), .off_o(pkt_frag_off_i), .pay_o(pkt_ip_pay_i));
   // one second is 200 cycles so a sweep of 32 cycles fits well inside it
   asps_screener #(.TICK_CYCLES(200)) i_asps_screener (.*, .chk_ip_land_i(ce[0]),
      .chk_mac_land_i(ce[1]), .equal_l4_port_check_i(ce[2]), .chk_icmp_size_i(ce[3]),
      .chk_tcp_flags_i(ce[4]), .chk_tcp_short_i(ce[5]), .first_fragment_check_i(ce[6]));

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic pk(input int k, input logic [47:0] m, input logic [7:0] p,
                     input logic d, input logic ml, input logic b);
      bit ok;
      int n;
      i_asps_ingress_model.send(k, m, p, ok);
      for (n = 0; n < 8 && ok; n++) begin
         @(negedge clk_i);
         if (verdict_valid_o === 1'b1) break;
      end
      if (!ok || n == 8) begin
         fails++;
         finish_test();
      end
      `CHK("drop", d, verdict_drop_o)
      `CHK("mal", ml, verdict_mal_o)
      `CHK("blk", b, verdict_blk_o)
      @(negedge clk_i);
   endtask

   // start right after a sweep so no tick or period end falls inside a burst
   task automatic sync();
      int i;
      int j;
      for (i = 0; i < 400 && flt_busy_o !== 1'b1; i++) @(negedge clk_i);
      for (j = 0; j < 100 && flt_busy_o !== 1'b0; j++) @(negedge clk_i);
      if (i == 400 || j == 100) begin
         fails++;
         finish_test();
      end
   endtask

   initial begin
      repeat (20) @(negedge clk_i);
      reset_n_i = 1'b1;
      for (int k = 1; k < 8; k++) begin
         pk(k, 48'h0200_0000_0010, 8'h01, 1'b0, 1'b0, 1'b0);
         ce = 7'h01 << (k - 1);
         pk(k, 48'h0200_0000_0010, 8'h01, 1'b1, 1'b1, 1'b0);
         pk(k % 7 + 1, 48'h0200_0000_0010, 8'h01, 1'b0, 1'b0, 1'b0);
         ce = 7'h00;
         chk_all_i = 1'b1;
         pk(k, 48'h0200_0000_0010, 8'h01, 1'b1, 1'b1, 1'b0);
         chk_all_i = 1'b0;
      end
      $display("test malformed done");
      flt_en_i = 1'b1;
      sync();
      for (int i = 0; i < 4; i++) pk(8, 48'h0200_0000_0021, 8'h01, 1'b0, 1'b0, 1'b0);
      pk(8, 48'h0200_0000_0021, 8'h01, 1'b1, 1'b0, 1'b1);
      pk(0, 48'h0200_0000_0021, 8'h01, 1'b1, 1'b0, 1'b1);
      pk(8, 48'h0200_0000_0021, 8'h02, 1'b0, 1'b0, 1'b0);
      repeat (800) @(negedge clk_i);
      pk(8, 48'h0200_0000_0021, 8'h01, 1'b0, 1'b0, 1'b0);
      $display("test raw done");
      flt_hybrid_i = 1'b1;
      sync();
      for (int i = 0; i < 4; i++) pk(8, 48'h0200_0000_0032, 8'h03, 1'b0, 1'b0, 1'b0);
      pk(8, 48'h0200_0000_0032, 8'h03, 1'b1, 1'b0, 1'b1);
      pk(0, 48'h0200_0000_0032, 8'h03, 1'b0, 1'b0, 1'b0);
      `CHK("hyb_used", 5'h01, hyb_used_o)
      flt_ip_i = 1'b1;
      sync();
      for (int i = 0; i < 4; i++) pk(0, 48'h0200_0000_0040, 8'h04, 1'b0, 1'b0, 1'b0);
      pk(0, 48'h0200_0000_0040, 8'h04, 1'b1, 1'b0, 1'b1);
      pk(8, 48'h0200_0000_0040, 8'h04, 1'b0, 1'b0, 1'b0);
      `CHK("hyb_used", 5'h02, hyb_used_o)
      flt_en_i = 1'b0;
      // ready stays low through the wipe, so the table is clear before this header is taken
      pk(8, 48'h0200_0000_0032, 8'h03, 1'b0, 1'b0, 1'b0);
      pk(0, 48'h0200_0000_0040, 8'h04, 1'b0, 1'b0, 1'b0);
      `CHK("hyb_used", 5'h00, hyb_used_o)
      $display("test hybrid done");
      finish_test();
   end
endmodule
